/* File: src/lsfs_pkg.sv */
// package: timing, variants and carrier types for the load switch fault sequencer
package lsfs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STARTUP_MS = 10;
  localparam int unsigned SLEEP_MS = 257;
  localparam int unsigned WAKE_MS = 1;
  localparam int unsigned SETTLE_MS = 10;
  localparam int unsigned BLANK_MS = 10;
  localparam int unsigned RESTART_MS = 70;
  localparam int unsigned START_BLANK_MS = 10;
  localparam int unsigned LIMIT_RESP_US = 15;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned STARTUP_CYC = STARTUP_MS * CYC_PER_MS;
  localparam int unsigned SLEEP_CYC = SLEEP_MS * CYC_PER_MS;
  localparam int unsigned WAKE_CYC = WAKE_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
  localparam int unsigned BLANK_CYC = BLANK_MS * CYC_PER_MS;
  localparam int unsigned RESTART_CYC = RESTART_MS * CYC_PER_MS;
  localparam int unsigned START_BLANK_CYC = START_BLANK_MS * CYC_PER_MS;
  localparam int unsigned LIMIT_RESP_CYC = LIMIT_RESP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 25;

  typedef enum logic [1:0] {
    LSFS_VAR_RESTART_HI,
    LSFS_VAR_RESTART_LO,
    LSFS_VAR_LATCH,
    LSFS_VAR_CONST_CUR
  } lsfs_variant_t;

  typedef enum {LSFS_STARTUP, LSFS_SLEEP, LSFS_WAKE, LSFS_ACTIVE} lsfs_mode_t;

  typedef struct packed {
    logic over_current;
    logic supply_low_lockout;
    logic supply_deep_low;
    logic over_temp;
  } lsfs_det_t;

  typedef struct packed {
    logic switch_on;
    logic slow_ramp;
    logic current_limit;
  } lsfs_sw_t;
endpackage

/* File: src/lsfs_sync.sv */
// two-flop synchroniser bank for the analog detector and control levels
`timescale 1ns/100ps
module lsfs_sync #(
  parameter int unsigned W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // lsfs_sync

/* File: src/lsfs_top.sv */
// load switch fault sequencer: mode cycle, blanking, restart, latch and flag drive
`timescale 1ns/100ps
module lsfs_top #(
  parameter lsfs_pkg::lsfs_variant_t VARIANT = lsfs_pkg::LSFS_VAR_RESTART_HI,
  parameter int unsigned STARTUP_CYC = lsfs_pkg::STARTUP_CYC,
  parameter int unsigned SLEEP_CYC = lsfs_pkg::SLEEP_CYC,
  parameter int unsigned WAKE_CYC = lsfs_pkg::WAKE_CYC,
  parameter int unsigned SETTLE_CYC = lsfs_pkg::SETTLE_CYC,
  parameter int unsigned BLANK_CYC = lsfs_pkg::BLANK_CYC,
  parameter int unsigned RESTART_CYC = lsfs_pkg::RESTART_CYC,
  parameter int unsigned START_BLANK_CYC = lsfs_pkg::START_BLANK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // host control pin
  input wire logic ctrl_in,
  // analog detectors (asynchronous levels)
  input wire lsfs_pkg::lsfs_det_t det_in,
  // switch drive
  output lsfs_pkg::lsfs_sw_t sw_out,
  // fault flag pin, active low
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  // mode visibility
  output lsfs_pkg::lsfs_mode_t mode_o
);
  localparam int unsigned CW = lsfs_pkg::CNT_W;
  localparam logic ACTIVE_LOW = (VARIANT == lsfs_pkg::LSFS_VAR_RESTART_LO);
  localparam logic BLANKING = (VARIANT != lsfs_pkg::LSFS_VAR_CONST_CUR);
  localparam logic RESTART = (VARIANT == lsfs_pkg::LSFS_VAR_RESTART_HI) || ACTIVE_LOW;

  function automatic logic cnt_done(input logic [CW-1:0] c, input int unsigned lim);
    cnt_done = (c >= CW'(lim - 1));
  endfunction

  logic [4:0] raw;
  logic [4:0] syn;
  lsfs_pkg::lsfs_det_t det;
  logic ctrl_s, ctrl_act, ctrl_prev_r, turn_on;

  assign raw = {ctrl_in, det_in};

  // reset leaves the control level at its inactive state for either polarity
  lsfs_sync #(.W(5), .RST_VAL({ACTIVE_LOW, 4'h0})) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(raw),
    .sync_out(syn)
  );

  assign ctrl_s = syn[4];
  assign det = syn[3:0];
  assign ctrl_act = ACTIVE_LOW ? ~ctrl_s : ctrl_s;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_prev_r <= 1'b0;
    end else begin
      ctrl_prev_r <= ctrl_act;
    end
  end
  assign turn_on = ctrl_act && !ctrl_prev_r;

  // mode sequencer
  lsfs_pkg::lsfs_mode_t mode_r, mode_nxt;
  logic [CW-1:0] mode_cnt_r;
  logic monitor, uv_seen, ot_seen, oc_fault;
  logic [CW-1:0] blank_cnt_r, rst_cnt_r, sblank_cnt_r;
  logic oc_trip_r, latched_r, restart_r, sblank_r;

  assign monitor = (mode_r != lsfs_pkg::LSFS_SLEEP);
  assign uv_seen = monitor && det.supply_low_lockout;
  assign ot_seen = monitor && det.over_temp;
  assign oc_fault = det.over_current;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      lsfs_pkg::LSFS_STARTUP: begin
        if (cnt_done(mode_cnt_r, STARTUP_CYC)) begin
          mode_nxt = (oc_fault || uv_seen || ot_seen) ? lsfs_pkg::LSFS_ACTIVE
                                                      : lsfs_pkg::LSFS_SLEEP;
        end
      end
      lsfs_pkg::LSFS_SLEEP: begin
        if (oc_fault || cnt_done(mode_cnt_r, SLEEP_CYC)) begin
          mode_nxt = lsfs_pkg::LSFS_WAKE;
        end
      end
      lsfs_pkg::LSFS_WAKE: begin
        if (oc_fault || uv_seen || ot_seen) begin
          mode_nxt = lsfs_pkg::LSFS_ACTIVE;
        end else if (cnt_done(mode_cnt_r, WAKE_CYC)) begin
          mode_nxt = lsfs_pkg::LSFS_SLEEP;
        end
      end
      lsfs_pkg::LSFS_ACTIVE: begin
        if (!oc_fault && !uv_seen && !ot_seen && !latched_r &&
            cnt_done(mode_cnt_r, SETTLE_CYC)) begin
          mode_nxt = lsfs_pkg::LSFS_SLEEP;
        end
      end
    endcase
    if (!ctrl_act) begin
      mode_nxt = lsfs_pkg::LSFS_STARTUP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_r <= lsfs_pkg::LSFS_STARTUP;
      mode_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_nxt != mode_r || !ctrl_act ||
          (mode_r == lsfs_pkg::LSFS_ACTIVE && (oc_fault || uv_seen || ot_seen))) begin
        mode_cnt_r <= '0;
      end else if (!(&mode_cnt_r)) begin
        mode_cnt_r <= mode_cnt_r + 1'b1;
      end
    end
  end

  // over-current blanking, restart and latch

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      blank_cnt_r <= '0;
      oc_trip_r <= 1'b0;
    end else if (!oc_fault || !ctrl_act || restart_r || latched_r) begin
      blank_cnt_r <= '0;
      oc_trip_r <= 1'b0;
    end else if (cnt_done(blank_cnt_r, BLANK_CYC)) begin
      oc_trip_r <= 1'b1;
    end else begin
      blank_cnt_r <= blank_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      restart_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (!RESTART || !ctrl_act) begin
      restart_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (restart_r) begin
      if (cnt_done(rst_cnt_r, RESTART_CYC)) begin
        restart_r <= 1'b0;
        rst_cnt_r <= '0;
      end else begin
        rst_cnt_r <= rst_cnt_r + 1'b1;
      end
    end else if (oc_trip_r) begin
      restart_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latched_r <= 1'b0;
    end else if (VARIANT != lsfs_pkg::LSFS_VAR_LATCH || !ctrl_act) begin
      latched_r <= 1'b0;
    end else if (oc_trip_r) begin
      latched_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sblank_r <= 1'b0;
      sblank_cnt_r <= '0;
    end else if (!ctrl_act || turn_on) begin
      sblank_r <= 1'b1;
      sblank_cnt_r <= '0;
    end else if (sblank_r) begin
      if (cnt_done(sblank_cnt_r, START_BLANK_CYC)) begin
        sblank_r <= 1'b0;
      end else begin
        sblank_cnt_r <= sblank_cnt_r + 1'b1;
      end
    end
  end

  // switch and flag outputs
  logic sw_on_nxt, flag_nxt, oc_flag, deep_cut, thermal_cut, lockout_cut;

  assign oc_flag = BLANKING ? (oc_trip_r || restart_r || latched_r)
                            : (oc_fault && !sblank_r);
  assign thermal_cut = ot_seen;
  assign lockout_cut = uv_seen;
  assign deep_cut = det.supply_deep_low;
  assign sw_on_nxt = ctrl_act && !thermal_cut && !lockout_cut && !deep_cut &&
                     !restart_r && !latched_r && !(BLANKING && oc_trip_r);
  assign flag_nxt = ctrl_act && (oc_flag || uv_seen || ot_seen);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_out <= '0;
    end else begin
      sw_out.switch_on <= sw_on_nxt;
      sw_out.slow_ramp <= sw_on_nxt && !sw_out.switch_on;
      sw_out.current_limit <= oc_fault;
    end
  end

  // open-drain: drive only while pulling low; push-pull drives high when on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_flag_n_o <= 1'b1;
      fault_flag_n_oe <= 1'b0;
      mode_o <= lsfs_pkg::LSFS_STARTUP;
    end else begin
      fault_flag_n_o <= !flag_nxt;
      fault_flag_n_oe <= flag_nxt || (ACTIVE_LOW && ctrl_act);
      mode_o <= mode_nxt;
    end
  end

  // protection and sequencing properties
  sw_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl_act |=> !sw_out.switch_on) else $error("switch on while control inactive");
  temp_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    ot_seen |=> !sw_out.switch_on) else $error("switch on during over-temperature");
  deep_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    det.supply_deep_low |=> !sw_out.switch_on) else $error("switch on at deep low");
  flag_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl_act && ot_seen) |=> !fault_flag_n_o && fault_flag_n_oe)
    else $error("flag not low on over-temperature");
  sleep_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_SLEEP && ctrl_act && !restart_r && !latched_r && !oc_trip_r &&
    !det.supply_deep_low) |=> sw_out.switch_on)
    else $error("switch opened by a masked detector in sleep");
  sleep_wake_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_SLEEP && oc_fault && ctrl_act) |=>
    mode_r == lsfs_pkg::LSFS_WAKE) else $error("sleep not left on current fault");
  wake_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_WAKE && oc_fault && ctrl_act) |=>
    mode_r == lsfs_pkg::LSFS_ACTIVE) else $error("wake went to sleep with fault");
  blank_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    (BLANKING && $rose(oc_fault) && ctrl_act) |=> (!oc_trip_r)[*2])
    else $error("flag inside blanking");
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (latched_r && ctrl_act) |=> latched_r || !ctrl_act)
    else $error("latch released without toggle");
  limit_resp_a: assert property (@(posedge sys_clk) disable iff (reset)
    oc_fault |-> ##[1:2] sw_out.current_limit) else $error("limit late");
  od_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!ACTIVE_LOW && fault_flag_n_oe) |-> !fault_flag_n_o)
    else $error("open-drain drove high");
  restart_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (restart_r && ctrl_act) |=> !sw_out.switch_on)
    else $error("switch on during restart hold");
  latch_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    (latched_r && ctrl_act) |=> !sw_out.switch_on && !fault_flag_n_o)
    else $error("latched fault not holding switch off and flag low");
  cc_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!BLANKING && ctrl_act && oc_fault && !sblank_r) |=> !fault_flag_n_o)
    else $error("constant-current overload not flagged");
  cc_conduct_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!BLANKING && ctrl_act && !uv_seen && !ot_seen && !det.supply_deep_low) |=> sw_out.switch_on)
    else $error("constant-current switch opened on overload");
  start_blank_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!BLANKING && sblank_r && ctrl_act && !uv_seen && !ot_seen) |=> fault_flag_n_o)
    else $error("flag inside startup blanking");
  flag_rel_a: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl_act |=> !fault_flag_n_oe) else $error("flag driven while shut down");
  startup_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_STARTUP && !cnt_done(mode_cnt_r, STARTUP_CYC)) |=>
    mode_r == lsfs_pkg::LSFS_STARTUP) else $error("startup check cut short");
  wake_clean_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_WAKE && ctrl_act && !oc_fault && !uv_seen && !ot_seen &&
    cnt_done(mode_cnt_r, WAKE_CYC)) |=> mode_r == lsfs_pkg::LSFS_SLEEP)
    else $error("clean wakeup did not return to sleep");
  fault_stay_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r == lsfs_pkg::LSFS_ACTIVE && (oc_fault || uv_seen || ot_seen)) |=>
    mode_r != lsfs_pkg::LSFS_SLEEP) else $error("sleep entered with fault present");
  thermal_back_a: assert property (@(posedge sys_clk) disable iff (reset)
    (mode_r != lsfs_pkg::LSFS_SLEEP && ctrl_act && !ot_seen && !uv_seen && !restart_r &&
    !latched_r && !oc_trip_r && !det.supply_deep_low) |=> sw_out.switch_on)
    else $error("switch not reclosed after faults cleared");

  // main scenarios
  sleep_c: cover property (@(posedge sys_clk) mode_r == lsfs_pkg::LSFS_SLEEP);
  wake_c: cover property (@(posedge sys_clk) mode_r == lsfs_pkg::LSFS_WAKE ##1
    mode_r == lsfs_pkg::LSFS_SLEEP);
  trip_c: cover property (@(posedge sys_clk) $rose(oc_trip_r));
  restart_c: cover property (@(posedge sys_clk) $fell(restart_r));
  latch_c: cover property (@(posedge sys_clk) $rose(latched_r));
endmodule // lsfs_top

/* File: tb/lsfs_host.sv */
// host model: drives the control pin and resolves the fault flag wire
`timescale 1ns/100ps
module lsfs_host #(
  parameter bit PUSH_PULL = 1'b0
) (
  // clock
  input wire logic sys_clk,
  // host request and flag pin
  input wire logic want_on,
  input wire logic flag_o,
  input wire logic flag_oe,
  output logic ctrl_in,
  output logic flag_seen
);
  logic last_r = 1'b1;
  // the push-pull variant takes a low level as active
  assign ctrl_in = PUSH_PULL ? ~want_on : want_on;
  // open-drain rests on the pull-up; a released push-pull line drifts
  assign flag_seen = flag_oe ? flag_o : (PUSH_PULL ? ~last_r : 1'b1);
  // remember only what was last driven, so a released line does not toggle
  always @(posedge sys_clk) if (flag_oe) last_r <= flag_o;
endmodule // lsfs_host

/* File: tb/lsfs_top_test.sv */
// self-checking bench: all four variants side by side, each with its own host model, all driven from one want_on
`timescale 1ns/100ps
module lsfs_top_test;
  localparam int ST = 40;
  localparam int SL = 60;
  localparam int WK = 20;
  localparam int SE = 40;
  localparam int BL = 30;
  localparam int RS = 50;
  localparam int SB = 30;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic want_on = 1'b0;
  logic ramp_seen;
  lsfs_pkg::lsfs_det_t det = '0;
  lsfs_pkg::lsfs_sw_t sw [4];
  lsfs_pkg::lsfs_mode_t md [4];
  logic fo [4];
  logic foe [4];
  logic fl [4];
  logic ct [4];
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'h0C6240A3;
  int len;

  for (genvar g = 0; g < 4; g++) begin : g_v
    lsfs_top #(.VARIANT(lsfs_pkg::lsfs_variant_t'(g)), .STARTUP_CYC(ST), .SLEEP_CYC(SL),
      .WAKE_CYC(WK), .SETTLE_CYC(SE), .BLANK_CYC(BL), .RESTART_CYC(RS),
      .START_BLANK_CYC(SB)) i_lsfs_top (.sys_clk(sys_clk), .reset(reset), .ctrl_in(ct[g]),
      .det_in(det), .sw_out(sw[g]), .fault_flag_n_o(fo[g]), .fault_flag_n_oe(foe[g]),
      .mode_o(md[g]));
    lsfs_host #(.PUSH_PULL(g == 1)) i_lsfs_host (.sys_clk(sys_clk), .want_on(want_on),
      .flag_o(fo[g]), .flag_oe(foe[g]), .ctrl_in(ct[g]), .flag_seen(fl[g]));
  end

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ramp_seen <= reset ? 1'b0 : (ramp_seen | sw[0].slow_ramp);
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic set_on(input logic v);
    @(posedge sys_clk);
    want_on <= v;
  endtask

  task automatic set_det(input logic [3:0] d);
    @(posedge sys_clk);
    det <= d;
  endtask

  // bit g of each mask is the expectation for variant g
  task automatic all_out(input logic [3:0] sw_exp, input logic [3:0] fl_exp);
    for (int g = 0; g < 4; g++) begin
      chk(sw[g].switch_on, sw_exp[g]);
      chk(fl[g], fl_exp[g]);
    end
  endtask

  task automatic wait_mode(input lsfs_pkg::lsfs_mode_t m, input int lo, input int hi);
    int n;
    n = 0;
    while (md[0] != m && n < hi) begin
      cyc(1);
      n++;
    end
    chk(n >= lo, 1'b1);
    for (int g = 0; g < 4; g++) chk(md[g], m);
  endtask

  initial begin
    cyc(8);
    for (int g = 0; g < 4; g++) chk({sw[g], foe[g]}, 4'h0);
    for (int g = 0; g < 4; g++) chk(md[g], lsfs_pkg::LSFS_STARTUP);
    @(posedge sys_clk);
    reset <= 1'b0;
    $display("test reset done");
    set_on(1'b1);
    cyc(4);
    all_out(4'hF, 4'hF);
    chk(ramp_seen, 1'b1);
    wait_mode(lsfs_pkg::LSFS_SLEEP, ST - 6, ST + 8);
    wait_mode(lsfs_pkg::LSFS_WAKE, SL - 2, SL + 4);
    wait_mode(lsfs_pkg::LSFS_SLEEP, WK - 2, WK + 4);
    $display("test mode cycle done");
    set_det(4'h5);
    cyc(10);
    all_out(4'hF, 4'hF);
    set_det(4'h0);
    cyc(4);
    set_det(4'h5);
    wait_mode(lsfs_pkg::LSFS_WAKE, SL - 20, SL + 4);
    cyc(5);
    all_out(4'h0, 4'h0);
    set_det(4'h0);
    cyc(6);
    all_out(4'hF, 4'hF);
    wait_mode(lsfs_pkg::LSFS_SLEEP, 0, 200);
    set_det(4'h2);
    cyc(4);
    for (int g = 0; g < 4; g++) chk(sw[g].switch_on, 1'b0);
    set_det(4'h0);
    set_on(1'b0);
    cyc(4);
    for (int g = 0; g < 4; g++) chk({sw[g].switch_on, foe[g]}, 2'h0);
    $display("test supply and thermal done");
    set_on(1'b1);
    wait_mode(lsfs_pkg::LSFS_SLEEP, ST - 2, ST + 8);
    set_det(4'h8);
    cyc(4);
    for (int g = 0; g < 4; g++) chk(md[g] != lsfs_pkg::LSFS_SLEEP, 1'b1);
    for (int g = 0; g < 4; g++) chk(sw[g].current_limit, 1'b1);
    cyc(8);
    all_out(4'hF, 4'h7);
    chk(sw[3].current_limit, 1'b1);
    set_det(4'h0);
    cyc(6);
    all_out(4'hF, 4'hF);
    wait_mode(lsfs_pkg::LSFS_SLEEP, SE - 10, SE + 8);
    set_det(4'h8);
    cyc(BL + 8);
    all_out(4'h8, 4'h0);
    set_det(4'h0);
    cyc(RS - 12);
    all_out(4'h8, 4'h8);
    cyc(16);
    all_out(4'hB, 4'hB);
    set_on(1'b0);
    cyc(3);
    set_on(1'b1);
    cyc(5);
    all_out(4'hF, 4'hF);
    set_det(4'h8);
    cyc(10);
    chk(fl[3], 1'b1);
    set_det(4'h0);
    $display("test overcurrent done");
    cyc(BL);
    for (int i = 0; i < 40; i++) begin
      len = 1 + $unsigned($random(seed)) % (BL - 8);
      set_det(4'h8);
      cyc(len);
      set_det(4'h0);
      cyc(3 + $unsigned($random(seed)) % 20);
      all_out(4'hF, 4'hF);
    end
    $display("test random pulses done");
    give_verdict();
  end
endmodule // lsfs_top_test
